/* File: rtl/input_edge_detect.sv */
// timer input synchroniser, optional noise filter and valid edge detector
module input_edge_detect (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pinIn,
    input wire logic sampleTick,
    input wire logic filterOn,
    input wire logic [1:0] edgeSel,
    output logic edgePulse
);
    import tpic_pkg::*;

    logic sync0_q;
    logic sync1_q;
    logic samp_q, samp_d;
    logic level_q, level_d;
    logic primed_q, primed_d;
    logic edge_q, edge_d;
    logic newLevel;
    logic rise;
    logic fall;

    always_comb begin
        samp_d = samp_q;
        level_d = level_q;
        primed_d = primed_q;
        edge_d = 1'b0;
        newLevel = level_q;
        rise = 1'b0;
        fall = 1'b0;
        if (sampleTick) begin
            samp_d = sync1_q;
            if (!filterOn || samp_q == sync1_q) begin
                newLevel = sync1_q;
            end
            level_d = newLevel;
            primed_d = 1'b1;
            // reset level is a guess, so no edge on the first sample
            rise = primed_q && newLevel && !level_q;
            fall = primed_q && !newLevel && level_q;
            case (edgeSel)
                EDGE_FALL: edge_d = fall;
                EDGE_RISE: edge_d = rise;
                EDGE_BOTH: edge_d = rise | fall;
                default: edge_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync0_q <= 1'b0;
            sync1_q <= 1'b0;
            samp_q <= 1'b0;
            level_q <= 1'b0;
            primed_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            sync0_q <= pinIn;
            sync1_q <= sync0_q;
            samp_q <= samp_d;
            level_q <= level_d;
            primed_q <= primed_d;
            edge_q <= edge_d;
        end
    end

    assign edgePulse = edge_q;
endmodule

/* File: rtl/timer_pulse_interval_capture.sv */
// one timer array channel measuring input pulse intervals, with its register port
//
// Chosen here: strobed register access and the placing of the registers.
`include "tpic_defs.svh"

module timer_pulse_interval_capture #(
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    input wire logic timerInputPin,
    output logic channelIrqPulse,
    output logic irqOut,
    output logic enabledStatus
);
    import tpic_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = '1;

    // unit level state
    logic moduleStop_q, moduleStop_d;
    logic [15:0] prescSel_q, prescSel_d;
    logic [15:0] divCnt_q, divCnt_d;
    logic filterEn_q, filterEn_d;
    logic [3:0] outCtrl_q, outCtrl_d;

    // channel state
    logic [15:0] mode_q, mode_d;
    chan_state_type state_q, state_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [CNT_W-1:0] capture_q, capture_d;
    logic ovfFlag_q, ovfFlag_d;
    logic ovfPend_q, ovfPend_d;
    logic chanIrq_q, chanIrq_d;
    logic enabled_q, enabled_d;

    // interrupt and read state
    logic [1:0] irqStat_q, irqStat_d;
    logic [1:0] irqMask_q, irqMask_d;
    logic irqOut_q, irqOut_d;
    logic [15:0] rdata_q, rdata_d;

    logic [3:0] ckTick;
    logic opTick;
    logic wrEn;
    logic startWr;
    logic stopWr;
    logic pinEdge;
    logic pinCapture;
    logic capEvt;
    logic startEvt;
    logic [1:0] irqClear;

    function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] sel);
        logic [15:0] m;
        m = (16'h0001 << sel) - 16'h0001;
        return (cnt & m) == m;
    endfunction

    function automatic logic pick_clock(input logic [3:0] ticks, input logic [1:0] cks);
        logic t;
        t = 1'b0;
        case (cks)
            2'h0: t = ticks[0];
            2'h1: t = ticks[2];
            2'h2: t = ticks[1];
            2'h3: t = ticks[3];
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
        return addr == target;
    endfunction

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_presc
            assign ckTick[k] = !moduleStop_q &&
                tick_of(divCnt_q, prescSel_q[k*`PRESC_FIELD_W +: `PRESC_FIELD_W]);
        end
    endgenerate

    assign opTick = pick_clock(ckTick, mode_q[`MODE_CKS_LSB +: 2]);

    assign wrEn = regWrite && !moduleStop_q;
    assign startWr = wrEn && hit(regAddr, `ADDR_START_TRIG) && regWdata[0];
    assign stopWr = wrEn && hit(regAddr, `ADDR_STOP_TRIG) && regWdata[0];

    input_edge_detect u_edge (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinIn(timerInputPin),
        .sampleTick(opTick),
        .filterOn(filterEn_q),
        .edgeSel(mode_q[`MODE_EDGE_LSB +: 2]),
        .edgePulse(pinEdge)
    );

    // pin edges act only with pin start select
    assign pinCapture = pinEdge && (mode_q[`MODE_STS_LSB +: 3] == `STS_PIN_EDGE);

    // unit group: module stop, prescaler, filter, output control
    always_comb begin
        moduleStop_d = moduleStop_q;
        prescSel_d = prescSel_q;
        filterEn_d = filterEn_q;
        outCtrl_d = outCtrl_q;
        divCnt_d = divCnt_q;
        // stop bit always writable, divider held at zero while set
        if (regWrite && hit(regAddr, `ADDR_MODULE_STOP)) begin
            moduleStop_d = regWdata[0];
        end
        if (moduleStop_q) begin
            divCnt_d = 16'h0000;
        end else begin
            divCnt_d = divCnt_q + 16'h0001;
        end
        if (wrEn && hit(regAddr, `ADDR_PRESCALER)) begin
            prescSel_d = regWdata;
        end
        if (wrEn && hit(regAddr, `ADDR_FILTER_EN)) begin
            filterEn_d = regWdata[0];
        end
        // held as written; software keeps these fixed while running
        if (wrEn && hit(regAddr, `ADDR_OUTPUT_CTRL)) begin
            outCtrl_d = regWdata[3:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            moduleStop_q <= `RST_MODULE_STOP;
            prescSel_q <= `RST_PRESCALER;
            filterEn_q <= 1'b0;
            outCtrl_q <= `RST_OUTPUT_CTRL;
            divCnt_q <= 16'h0000;
        end else begin
            moduleStop_q <= moduleStop_d;
            prescSel_q <= prescSel_d;
            filterEn_q <= filterEn_d;
            outCtrl_q <= outCtrl_d;
            divCnt_q <= divCnt_d;
        end
    end

    // channel group: mode, counter, capture, overflow
    always_comb begin
        mode_d = mode_q;
        state_d = state_q;
        count_d = count_q;
        capture_d = capture_q;
        ovfFlag_d = ovfFlag_q;
        ovfPend_d = ovfPend_q;
        chanIrq_d = 1'b0;
        capEvt = 1'b0;
        startEvt = 1'b0;
        // only the edge select field should move while running; not enforced
        if (wrEn && hit(regAddr, `ADDR_CHANNEL_MODE)) begin
            mode_d = regWdata;
        end
        if (moduleStop_q) begin
            state_d = CH_STOPPED;
        end else begin
            unique case (state_q)
                CH_STOPPED: begin
                    if (startWr) begin
                        state_d = CH_RUNNING;
                        count_d = CNT_ZERO;
                        ovfPend_d = 1'b0;
                        if (mode_q[`MODE_IRQ_BIT]) begin
                            chanIrq_d = 1'b1;
                            startEvt = 1'b1;
                        end
                    end
                end
                CH_RUNNING: begin
                    if (stopWr) begin
                        state_d = CH_STOPPED;
                    end else if (startWr || pinCapture) begin
                        capture_d = count_q;
                        count_d = CNT_ZERO;
                        chanIrq_d = 1'b1;
                        capEvt = 1'b1;
                        ovfFlag_d = ovfPend_q;
                        ovfPend_d = 1'b0;
                    end else if (opTick) begin
                        count_d = count_q + CNT_ONE;
                        if (count_q == CNT_FULL) begin
                            ovfPend_d = 1'b1;
                        end
                    end
                end
            endcase
        end
        enabled_d = (state_d == CH_RUNNING);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= `RST_MODE;
            state_q <= CH_STOPPED;
            count_q <= CNT_ZERO;
            capture_q <= CNT_ZERO;
            ovfFlag_q <= 1'b0;
            ovfPend_q <= 1'b0;
            chanIrq_q <= 1'b0;
            enabled_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            state_q <= state_d;
            count_q <= count_d;
            capture_q <= capture_d;
            ovfFlag_q <= ovfFlag_d;
            ovfPend_q <= ovfPend_d;
            chanIrq_q <= chanIrq_d;
            enabled_q <= enabled_d;
        end
    end

    // interrupt and read group
    always_comb begin
        irqMask_d = irqMask_q;
        irqClear = 2'h0;
        if (wrEn && hit(regAddr, `ADDR_IRQ_MASK)) begin
            irqMask_d = regWdata[1:0];
        end
        if (wrEn && hit(regAddr, `ADDR_IRQ_STATUS)) begin
            irqClear = regWdata[1:0];
        end
        // a new event beats a clear in the same cycle
        irqStat_d = irqStat_q & ~irqClear;
        if (capEvt) begin
            irqStat_d[`IRQ_CAPTURE_BIT] = 1'b1;
        end
        if (startEvt) begin
            irqStat_d[`IRQ_START_BIT] = 1'b1;
        end
        irqOut_d = |(irqStat_d & irqMask_d);
        rdata_d = 16'h0000;
        if (regRead) begin
            case (regAddr)
                `ADDR_MODULE_STOP: rdata_d = {15'h0000, moduleStop_q};
                `ADDR_PRESCALER: rdata_d = prescSel_q;
                `ADDR_FILTER_EN: rdata_d = {15'h0000, filterEn_q};
                `ADDR_CHANNEL_MODE: rdata_d = mode_q;
                `ADDR_ENABLED: rdata_d = {15'h0000, enabled_q};
                `ADDR_COUNTER: rdata_d = 16'(count_q);
                `ADDR_CAPTURE: rdata_d = 16'(capture_q);
                `ADDR_CHAN_STATUS: rdata_d = {15'h0000, ovfFlag_q};
                `ADDR_IRQ_STATUS: rdata_d = {14'h0000, irqStat_q};
                `ADDR_IRQ_MASK: rdata_d = {14'h0000, irqMask_q};
                `ADDR_OUTPUT_CTRL: rdata_d = {12'h000, outCtrl_q};
                // trigger registers and holes read as zero
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStat_q <= 2'h0;
            irqMask_q <= 2'h0;
            irqOut_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            irqOut_q <= irqOut_d;
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
    assign channelIrqPulse = chanIrq_q;
    assign irqOut = irqOut_q;
    assign enabledStatus = enabled_q;
endmodule

/* File: rtl/tpic_defs.svh */
// register offsets, field positions, reset values and counts for the interval capture channel
// Function
// - module stop halts clock, blocks writes except to module stop
// - prescaler select sets four prescaled clocks
// - per-channel input noise filter enable bit
// - start trigger enables channel, clears counter
// - start irq option pulses irq at start
// - enabled counter counts up on tick
// - valid edge or start copies count
// - capture clears counter, pulses channel irq
// - capture updates overflow flag from period
// - capture, counter, status always readable
// - stop trigger disables, counter holds value
// - stop keeps overflow flag unchanged
// - edge select falling, rising or both
// - multiple overflows still set overflow flag
`ifndef TPIC_DEFS_SVH
`define TPIC_DEFS_SVH

`define ADDR_MODULE_STOP 4'h0
`define ADDR_PRESCALER 4'h1
`define ADDR_FILTER_EN 4'h2
`define ADDR_CHANNEL_MODE 4'h3
`define ADDR_START_TRIG 4'h4
`define ADDR_STOP_TRIG 4'h5
`define ADDR_ENABLED 4'h6
`define ADDR_COUNTER 4'h7
`define ADDR_CAPTURE 4'h8
`define ADDR_CHAN_STATUS 4'h9
`define ADDR_IRQ_STATUS 4'hA
`define ADDR_IRQ_MASK 4'hB
`define ADDR_OUTPUT_CTRL 4'hC

`define MODE_IRQ_BIT 0
`define MODE_MD_LSB 1
`define MODE_EDGE_LSB 6
`define MODE_STS_LSB 8
`define MODE_CKS_LSB 14
`define STS_PIN_EDGE 3'h1

`define IRQ_CAPTURE_BIT 0
`define IRQ_START_BIT 1

`define RST_MODULE_STOP 1'b1
`define RST_PRESCALER 16'h0000
`define RST_MODE 16'h0000
`define RST_OUTPUT_CTRL 4'h0
`define COUNT_ZERO 16'h0000
`define PRESC_FIELD_W 4

`endif

/* File: rtl/tpic_pkg.sv */
// types shared by the interval capture channel files
package tpic_pkg;
    typedef enum logic [1:0] {
        CH_STOPPED = 2'b01,
        CH_RUNNING = 2'b10
    } chan_state_type;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2
    } edge_sel_type;
endpackage

/* File: tb/pulse_source.sv */
// external pulse source driving the timer input pin
module pulse_source (
    input wire logic core_clk,
    input wire logic toggleReq,
    input wire logic glitchReq,
    output logic pinOut
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pinOut = 1'b0;
    // edges land 7 ns after the clock, so the pin is truly asynchronous
    always @(posedge core_clk) begin
        if (toggleReq) begin
            pinOut <= #7 ~pinOut;
        end else if (glitchReq) begin
            pinOut <= #7 1'b1;
            pinOut <= #57 1'b0;
        end
    end
endmodule

/* File: tb/timer_pulse_interval_capture_checker.sv */
// port-level checks for the interval capture channel
module timer_pulse_interval_capture_checker #(
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic timerInputPin,
    input wire logic channelIrqPulse,
    input wire logic irqOut,
    input wire logic enabledStatus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic unitOff_q, unitOff_d, startW, stopW, offW;
    logic [1:0] mask_q, mask_d;
    assign startW = regWrite && regAddr == 4'h4 && regWdata[0];
    assign stopW = regWrite && regAddr == 4'h5 && regWdata[0];
    assign offW = regWrite && regAddr == 4'h0 && regWdata[0];
    // mirror of module stop and mask, since writes are refused while off
    always_comb begin
        unitOff_d = unitOff_q;
        mask_d = mask_q;
        if (regWrite && regAddr == 4'h0)
            unitOff_d = regWdata[0];
        if (regWrite && regAddr == 4'hB && !unitOff_q)
            mask_d = regWdata[1:0];
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unitOff_q <= 1'b1;
            mask_q <= 2'h0;
        end else begin
            unitOff_q <= unitOff_d;
            mask_q <= mask_d;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence startSeq;
        startW && !unitOff_q;
    endsequence
    sequence trigReadSeq;
        regRead && (regAddr == 4'h4 || regAddr == 4'h5);
    endsequence
    chk_start_enables: assert property (startSeq |=> enabledStatus)
        else $error("start write left channel stopped");
    chk_stop_halts: assert property (stopW |=> !enabledStatus)
        else $error("stop write left channel running");
    // the channel drops one cycle after the stop bit lands
    chk_unit_off: assert property (unitOff_q && $past(unitOff_q) |-> !enabledStatus)
        else $error("channel runs while unit is off");
    chk_enable_cause: assert property ($rose(enabledStatus) |-> $past(startW))
        else $error("channel enabled without start write");
    chk_disable_cause: assert property ($fell(enabledStatus) |-> $past(stopW) || $past(unitOff_q))
        else $error("channel stopped without stop write");
    chk_pulse_running: assert property (channelIrqPulse |-> enabledStatus)
        else $error("irq pulse while channel stopped");
    chk_trig_reads: assert property (trigReadSeq |=> regRdata == 16'h0000)
        else $error("trigger register read nonzero");
    chk_rdata_idle: assert property (!regRead |=> regRdata == 16'h0000)
        else $error("read data outside read cycle");
    chk_irq_follows: assert property (channelIrqPulse && mask_q == 2'h3 && $stable(mask_q)
        |-> irqOut)
        else $error("unmasked event gave no irq level");
endmodule

bind timer_pulse_interval_capture timer_pulse_interval_capture_checker #(.CNT_W(CNT_W)) chk (
    .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .timerInputPin(timerInputPin), .channelIrqPulse(channelIrqPulse), .irqOut(irqOut),
    .enabledStatus(enabledStatus));

/* File: tb/timer_pulse_interval_capture_test.sv */
// self-checking bench for the interval capture channel
module timer_pulse_interval_capture_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, regWrite, regRead, toggleReq, glitchReq;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata;
    logic timerInputPin, channelIrqPulse, irqOut, enabledStatus;
    int errCount = 0;
    int samplesChecked = 0;
    // short counter so overflow shows within a few dozen cycles
    timer_pulse_interval_capture #(.CNT_W(4)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .timerInputPin(timerInputPin), .channelIrqPulse(channelIrqPulse),
        .irqOut(irqOut), .enabledStatus(enabledStatus));
    pulse_source src (.core_clk(core_clk), .toggleReq(toggleReq), .glitchReq(glitchReq),
        .pinOut(timerInputPin));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        cmp(what, exp, regRdata);
    endtask
    // one pin event, then count irq pulses over a fixed window
    task automatic pinPulses(input logic glitch, input logic [15:0] exp, input string what);
        logic [15:0] n;
        n = 16'h0000;
        @(posedge core_clk);
        toggleReq <= !glitch;
        glitchReq <= glitch;
        @(posedge core_clk);
        toggleReq <= 1'b0;
        glitchReq <= 1'b0;
        repeat (12) begin
            #1;
            n = n + {15'h0000, channelIrqPulse};
            @(posedge core_clk);
        end
        cmp(what, exp, n);
    endtask
    task automatic testUnitOff;
        rd(4'h0, 16'h0001, "stop reset");
        wr(4'h4, 16'h0001);
        cmp("enabled off", 16'h0000, {15'h0000, enabledStatus});
        rd(4'hF, 16'h0000, "unmapped");
    endtask
    task automatic testStartCapture;
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0000);
        wr(4'h2, 16'h0000);
        wr(4'hB, 16'h0003);
        wr(4'h3, 16'h0141);
        wr(4'h4, 16'h0001);
        cmp("start pulse", 16'h0001, {15'h0000, channelIrqPulse});
        cmp("enabled", 16'h0001, {15'h0000, enabledStatus});
        wr(4'h4, 16'h0001);
        cmp("capture pulse", 16'h0001, {15'h0000, channelIrqPulse});
        rd(4'h8, 16'h0001, "capture");
        rd(4'h9, 16'h0000, "ovf clear");
        rd(4'h4, 16'h0000, "start reads");
    endtask
    task automatic testEdges;
        for (int e = 0; e < 4; e++) begin
            wr(4'h3, 16'h0101 | (16'(e) << 6));
            pinPulses(1'b0, {15'h0000, e == 1 || e == 2}, "rise");
            pinPulses(1'b0, {15'h0000, e == 0 || e == 2}, "fall");
        end
        wr(4'h3, 16'h0181);
        pinPulses(1'b1, 16'h0002, "glitch raw");
        wr(4'h2, 16'h0001);
        pinPulses(1'b1, 16'h0000, "glitch filtered");
        cmp("irq level", 16'h0001, {15'h0000, irqOut});
        wr(4'hA, 16'h0003);
        rd(4'hA, 16'h0000, "irq cleared");
        cmp("irq low", 16'h0000, {15'h0000, irqOut});
        wr(4'hB, 16'h0000);
        pinPulses(1'b0, 16'h0001, "masked edge");
        rd(4'hA, 16'h0001, "status set");
        cmp("irq masked", 16'h0000, {15'h0000, irqOut});
        wr(4'hB, 16'h0003);
        rd(4'hB, 16'h0003, "mask");
        cmp("irq unmasked", 16'h0001, {15'h0000, irqOut});
    endtask
    task automatic testOverflow;
        wr(4'h4, 16'h0001);
        repeat (20) @(posedge core_clk);
        wr(4'h4, 16'h0001);
        rd(4'h9, 16'h0001, "ovf set");
        wr(4'h4, 16'h0001);
        rd(4'h9, 16'h0000, "ovf cleared");
        repeat (40) @(posedge core_clk);
        wr(4'h4, 16'h0001);
        wr(4'h5, 16'h0001);
        cmp("stopped", 16'h0000, {15'h0000, enabledStatus});
        rd(4'h9, 16'h0001, "ovf held");
        rd(4'h7, 16'h0001, "count held");
        pinPulses(1'b0, 16'h0000, "edge stopped");
        wr(4'h4, 16'h0001);
        rd(4'h7, 16'h0001, "restart count");
    endtask
    // quarter-rate clock one reached through clock select; a wrong pick counts 8
    task automatic testPrescaler;
        wr(4'h5, 16'h0001);
        wr(4'hC, 16'h0005);
        rd(4'hC, 16'h0005, "output ctrl");
        wr(4'h1, 16'h0020);
        wr(4'h3, 16'h8140);
        wr(4'h4, 16'h0001);
        cmp("no start pulse", 16'h0000, {15'h0000, channelIrqPulse});
        repeat (7) @(posedge core_clk);
        wr(4'h4, 16'h0001);
        rd(4'h8, 16'h0002, "prescaled capture");
    endtask
    task automatic testShutdown;
        wr(4'h0, 16'h0001);
        // the channel drops one cycle after the stop bit lands
        @(posedge core_clk);
        #1;
        cmp("off stops", 16'h0000, {15'h0000, enabledStatus});
        wr(4'hB, 16'h0000);
        rd(4'hB, 16'h0003, "write refused");
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        toggleReq = 1'b0;
        glitchReq = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        testUnitOff();
        testStartCapture();
        testEdges();
        testOverflow();
        testPrescaler();
        testShutdown();
        finishTest();
    end
endmodule
